// ### core/freq_input_measure.sv
// Eight-channel frequency and digital input conditioning and measurement block.
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps

// Functional notes
// - Digital mode applies a programmable debounce so a bouncing switch gives one transition.
// - Digital rising threshold sets when the digital value goes high, digital path only.
// - Digital falling threshold sets when the value goes low, forming hysteresis.
// - In encoder mode a pair selector picks the phase pair, 1 being the first.
// - A programmable low-pass filters reported frequency, duty and voltage.
// - Over-voltage fault rises when input voltage exceeds the upper limit.
// - Under-voltage fault rises when input voltage falls below the lower limit.
// - On channels 1 and 2, frequency rising threshold is adaptive peak-detect or fixed 2.2 V.
// - On channels 1 and 2, frequency falling threshold is 1.0 V or 0 V.
// - Termination selects open, load supply, 5 V, ground, or 5 V and ground.
// - Frequency mode acts as a digital input and also measures frequency.
// - Up to 8, 6, 4 or 2 channels may run in frequency mode, per model.
// - Channels 1 and 2 accept differential signals; the rest are single-ended.
// - No duty cycle on the two differential channels.
// - Pulses shorter than 20 us may be missed by edge measurements.
// - Frequency-mode channels report no input voltage.
// - Single-ended channels 3 to 8 trigger at 3 V rising and 2 V falling.
// - Total-frequency warning when summed input frequency exceeds 200 kHz; operation continues.
// - Digital inputs are sampled at 200 Hz with debounce applied.
// - Reported digital value is the result after thresholds and debounce.
// - Each channel has a pulse counter that wraps on overflow.
module freq_input_measure
  import freq_input_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYC,
  parameter int WINDOW_CYCLES = WINDOW_CYC,
  parameter int FREQ_CHANNELS = NUM_CH
)(
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       ce,
  input  wire logic [ADDR_W-1:0]          addr,
  input  wire logic [31:0]                wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic      [31:0]                rdata,
  input  wire volt_s                      volt,
  input  wire logic [NUM_CH-1:0]          cmp_in,
  output term_e     [NUM_CH-1:0]          term,
  output thr_s      [NUM_CH-1:0]          freq_thr,
  output logic      [NUM_CH-1:0]          digital_value,
  output logic      [NUM_CH-1:0]          ov_fault,
  output logic      [NUM_CH-1:0]          uv_fault,
  output logic                            total_freq_fault
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    cfg_s                       cfg;
    logic [7:0]                 debounce;
    logic signed [VOLT_W-1:0]   din_rise;
    logic signed [VOLT_W-1:0]   din_fall;
    logic signed [VOLT_W-1:0]   ov_lim;
    logic signed [VOLT_W-1:0]   uv_lim;
    logic                       hyst;
    logic                       dig;
    logic [7:0]                 db_cnt;
    logic                       lvl;
    logic [15:0]                gl_cnt;
    logic                       seen_rise;
    logic [TS_W-1:0]            last_rise;
    logic [TS_W-1:0]            period;
    logic [TS_W-1:0]            high;
    logic [TS_W-1:0]            phase;
    logic [15:0]                count;
    logic signed [TS_W-1:0]     volt_f;
    logic                       ov;
    logic                       uv;
    thr_s                       thr;
  } ch_s;

  typedef struct packed {
    ch_s [NUM_CH-1:0]           ch;
    logic [TS_W-1:0]            tb;
    logic [31:0]                tick_cnt;
    logic [31:0]                win_cnt;
    logic [15:0]                edge_sum;
    logic                       tf_fault;
    logic [31:0]                rdata;
  } st_s;

  st_s st;
  st_s next_st;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // First-order low-pass: old + (new - old) >>> shift.
  function automatic logic [TS_W-1:0] lpf(input logic [TS_W-1:0] old_v, input logic [TS_W-1:0] new_v,
                                          input logic [2:0] shift);
    logic signed [TS_W:0] diff;
    diff = $signed({new_v[TS_W-1], new_v}) - $signed({old_v[TS_W-1], old_v});
    return old_v + TS_W'(diff >>> shift);
  endfunction : lpf

  // Combinational view of the channels and decode.
  logic [2:0]            ch_sel;
  logic [3:0]            reg_sel;
  logic [NUM_CH-1:0]     rise_e;
  logic [NUM_CH-1:0]     fall_e;
  logic [1:0]            pidx;
  logic [2:0]            pa;
  logic [2:0]            pb;
  logic                  tick;
  logic                  win_end;
  logic [15:0]           edges_now;
  logic signed [TS_W-1:0] vs;

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  // Computes all channel measurements, register writes and read data.
  always_comb
  begin
    next_st   = st;
    ch_sel    = addr[6:4];
    reg_sel   = addr[3:0];
    rise_e    = '0;
    fall_e    = '0;
    pidx      = '0;
    pa        = '0;
    pb        = '0;
    edges_now = '0;
    vs        = '0;
    next_st.tb = st.tb + 1'b1;
    tick      = (st.tick_cnt == 32'(SAMPLE_CYCLES - 1));
    win_end   = (st.win_cnt == 32'(WINDOW_CYCLES - 1));
    next_st.tick_cnt = tick ? '0 : st.tick_cnt + 1'b1;
    next_st.win_cnt  = win_end ? '0 : st.win_cnt + 1'b1;

    // Edge qualification: the comparator level must hold half a minimum pulse.
    // A level change shorter than the filter restarts the count, so narrow glitches vanish.
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (cmp_in[i] != st.ch[i].lvl && st.ch[i].cfg.mode != MODE_DIGITAL && i < FREQ_CHANNELS)
      begin
        next_st.ch[i].gl_cnt = st.ch[i].gl_cnt + 1'b1;
        if (st.ch[i].gl_cnt == 16'(GLITCH_CYC - 1))
        begin
          next_st.ch[i].gl_cnt = '0;
          next_st.ch[i].lvl    = cmp_in[i];
          rise_e[i] = cmp_in[i];
          fall_e[i] = !cmp_in[i];
        end
      end
      else
      begin
        next_st.ch[i].gl_cnt = '0;
      end
    end

    // Per-channel measurement from edge timestamps.
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (rise_e[i])
      begin
        next_st.ch[i].count     = st.ch[i].count + 1'b1;
        next_st.ch[i].last_rise = st.tb;
        next_st.ch[i].seen_rise = 1'b1;
        if (st.ch[i].seen_rise)
        begin
          next_st.ch[i].period = lpf(st.ch[i].period, st.tb - st.ch[i].last_rise,
                                     st.ch[i].cfg.tc_shift);
        end
      end
      if (fall_e[i] && st.ch[i].seen_rise && i >= DIFF_CH)
      begin
        next_st.ch[i].high = lpf(st.ch[i].high, st.tb - st.ch[i].last_rise, st.ch[i].cfg.tc_shift);
      end
      // Phase: time from the first pair member's rise to the second one's rise.
      // Pair codes beyond the last pair wrap onto the low pairs, so software must keep them in range.
      pidx = (st.ch[i].cfg.pair == 3'h0) ? 2'h0 : 2'(st.ch[i].cfg.pair - 3'h1);
      pa   = {pidx, 1'b0};
      pb   = {pidx, 1'b1};
      if (st.ch[i].cfg.mode == MODE_ENCODER && rise_e[pb])
      begin
        next_st.ch[i].phase = st.tb - st.ch[pa].last_rise;
      end
      edges_now = edges_now + 16'(rise_e[i]);
    end

    // Summed edge count over the window against the total-frequency limit.
    next_st.edge_sum = st.edge_sum + edges_now;
    if (win_end)
    begin
      next_st.edge_sum = '0;
      next_st.tf_fault = (st.edge_sum + edges_now) > TOTAL_EDGE_LIMIT;
    end

    // Voltage path: filtering, over- and under-voltage limits.
    if (volt.valid)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        vs = TS_W'($signed(volt.mv[i]));
        next_st.ch[i].ov = $signed(volt.mv[i]) > st.ch[i].ov_lim;
        next_st.ch[i].uv = $signed(volt.mv[i]) < st.ch[i].uv_lim;
        next_st.ch[i].volt_f = lpf(st.ch[i].volt_f, vs, st.ch[i].cfg.tc_shift);
      end
    end

    // 200 Hz sampling: hysteresis then debounce give the digital value.
    if (tick)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        if ($signed(volt.mv[i]) >= st.ch[i].din_rise)
        begin
          next_st.ch[i].hyst = 1'b1;
        end
        else if ($signed(volt.mv[i]) <= st.ch[i].din_fall)
        begin
          next_st.ch[i].hyst = 1'b0;
        end
        if (st.ch[i].hyst != st.ch[i].dig)
        begin
          next_st.ch[i].db_cnt = st.ch[i].db_cnt + 1'b1;
          if (st.ch[i].db_cnt >= st.ch[i].debounce)
          begin
            next_st.ch[i].dig    = st.ch[i].hyst;
            next_st.ch[i].db_cnt = '0;
          end
        end
        else
        begin
          next_st.ch[i].db_cnt = '0;
        end
      end
    end

    // Comparator levels driven to the analog front end.
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (i < DIFF_CH)
      begin
        next_st.ch[i].thr.adaptive = !st.ch[i].cfg.rise_fixed;
        next_st.ch[i].thr.rise_mv  = FIX_RISE_DIFF_MV;
        next_st.ch[i].thr.fall_mv  = st.ch[i].cfg.fall_zero ? FALL_LO_DIFF_MV : FALL_HI_DIFF_MV;
      end
      else
      begin
        next_st.ch[i].thr.adaptive = 1'b0;
        next_st.ch[i].thr.rise_mv  = SE_RISE_MV;
        next_st.ch[i].thr.fall_mv  = SE_FALL_MV;
      end
    end

    // Register writes.
    // A count write wins over a rise accepted in the same cycle, and that rise is lost.
    if (wr)
    begin
      unique case (reg_sel)
        REG_CFG:      next_st.ch[ch_sel].cfg      = cfg_s'(wdata[12:0]);
        REG_DEBOUNCE: next_st.ch[ch_sel].debounce = wdata[7:0];
        REG_DIN_RISE: next_st.ch[ch_sel].din_rise = wdata[VOLT_W-1:0];
        REG_DIN_FALL: next_st.ch[ch_sel].din_fall = wdata[VOLT_W-1:0];
        REG_OV_LIMIT: next_st.ch[ch_sel].ov_lim   = wdata[VOLT_W-1:0];
        REG_UV_LIMIT: next_st.ch[ch_sel].uv_lim   = wdata[VOLT_W-1:0];
        REG_COUNT:    next_st.ch[ch_sel].count    = wdata[15:0];
        default:      ;
      endcase
    end

    // Read data stands for exactly the cycle after the strobe.
    next_st.rdata = '0;
    if (rd)
    begin
      unique case (reg_sel)
        REG_CFG:      next_st.rdata = 32'(st.ch[ch_sel].cfg);
        REG_DEBOUNCE: next_st.rdata = 32'(st.ch[ch_sel].debounce);
        REG_DIN_RISE: next_st.rdata = 32'($signed(st.ch[ch_sel].din_rise));
        REG_DIN_FALL: next_st.rdata = 32'($signed(st.ch[ch_sel].din_fall));
        REG_OV_LIMIT: next_st.rdata = 32'($signed(st.ch[ch_sel].ov_lim));
        REG_UV_LIMIT: next_st.rdata = 32'($signed(st.ch[ch_sel].uv_lim));
        REG_VOLTAGE:  next_st.rdata = (st.ch[ch_sel].cfg.mode == MODE_DIGITAL) ?
                                      st.ch[ch_sel].volt_f : '0;
        REG_PERIOD:   next_st.rdata = st.ch[ch_sel].period;
        REG_HIGH:     next_st.rdata = st.ch[ch_sel].high;
        REG_PHASE:    next_st.rdata = st.ch[ch_sel].phase;
        REG_COUNT:    next_st.rdata = 32'(st.ch[ch_sel].count);
        REG_STATUS:   next_st.rdata = {28'h0, st.tf_fault, st.ch[ch_sel].uv, st.ch[ch_sel].ov,
                                       st.ch[ch_sel].dig};
        default:      next_st.rdata = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  // Synchronous reset, clock enable freezes everything.
  // Reset is not gated by the enable, so a frozen block can still be brought back to its defaults.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st <= '0;
      for (int i = 0; i < NUM_CH; i++)
      begin
        st.ch[i].cfg      <= CFG_RST;
        st.ch[i].debounce <= DEBOUNCE_RST;
        st.ch[i].din_rise <= DIN_RISE_RST;
        st.ch[i].din_fall <= DIN_FALL_RST;
        st.ch[i].ov_lim   <= OV_RST;
        st.ch[i].uv_lim   <= UV_RST;
      end
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // All outputs are taken straight from state flip-flops.
  always_comb
  begin
    rdata            = st.rdata;
    total_freq_fault = st.tf_fault;
    for (int i = 0; i < NUM_CH; i++)
    begin
      term[i]          = st.ch[i].cfg.term;
      freq_thr[i]      = st.ch[i].thr;
      digital_value[i] = st.ch[i].dig;
      ov_fault[i]      = st.ch[i].ov;
      uv_fault[i]      = st.ch[i].uv;
    end
  end

endmodule : freq_input_measure

// ### core/freq_input_pkg.sv
// Package with constants, register map and carrier types of the frequency/digital input block.
package freq_input_pkg;

  // ---------------------------------------------------------------------------
  // Sizes and timing
  // ---------------------------------------------------------------------------
  localparam int NUM_CH          = 8;
  localparam int DIFF_CH         = 2;        // Channels 0 and 1 are the differential pair inputs.
  localparam int VOLT_W          = 18;       // Signed millivolt samples.
  localparam int TS_W            = 32;
  localparam int CLK_HZ          = 100000000;
  localparam int SAMPLE_HZ       = 200;
  localparam int SAMPLE_CYC      = CLK_HZ / SAMPLE_HZ;
  localparam int MIN_PULSE_NS    = 20000;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int MIN_PULSE_CYC   = MIN_PULSE_NS / CLK_PERIOD_NS;
  localparam int GLITCH_CYC      = MIN_PULSE_CYC / 2;
  localparam int TOTAL_FREQ_KHZ  = 200;
  localparam int WINDOW_MS       = 1;
  localparam int WINDOW_CYC      = CLK_HZ / 1000 * WINDOW_MS;
  localparam logic [15:0] TOTAL_EDGE_LIMIT = 16'(TOTAL_FREQ_KHZ * WINDOW_MS);

  // ---------------------------------------------------------------------------
  // Fixed frequency comparator levels in millivolts
  // ---------------------------------------------------------------------------
  localparam logic [15:0] FIX_RISE_DIFF_MV = 16'h0898;  // 2200 mV.
  localparam logic [15:0] FALL_HI_DIFF_MV  = 16'h03E8;  // 1000 mV.
  localparam logic [15:0] FALL_LO_DIFF_MV  = 16'h0000;  // 0 mV.
  localparam logic [15:0] SE_RISE_MV       = 16'h0BB8;  // 3000 mV.
  localparam logic [15:0] SE_FALL_MV       = 16'h07D0;  // 2000 mV.

  // ---------------------------------------------------------------------------
  // Register map: address = {channel[2:0], register[3:0]}
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam logic [3:0] REG_CFG      = 4'h0;
  localparam logic [3:0] REG_DEBOUNCE = 4'h1;
  localparam logic [3:0] REG_DIN_RISE = 4'h2;
  localparam logic [3:0] REG_DIN_FALL = 4'h3;
  localparam logic [3:0] REG_OV_LIMIT = 4'h4;
  localparam logic [3:0] REG_UV_LIMIT = 4'h5;
  localparam logic [3:0] REG_VOLTAGE  = 4'h8;
  localparam logic [3:0] REG_PERIOD   = 4'h9;
  localparam logic [3:0] REG_HIGH     = 4'hA;
  localparam logic [3:0] REG_PHASE    = 4'hB;
  localparam logic [3:0] REG_COUNT    = 4'hC;
  localparam logic [3:0] REG_STATUS   = 4'hD;

  // ---------------------------------------------------------------------------
  // Configuration fields and reset values
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {MODE_DIGITAL = 2'h0, MODE_FREQ = 2'h1, MODE_ENCODER = 2'h3} mode_e;
  typedef enum logic [2:0] {
    TERM_OPEN = 3'h0, TERM_LOAD_SUPPLY = 3'h1, TERM_5V = 3'h2, TERM_GND = 3'h3, TERM_5V_GND = 3'h4
  } term_e;

  typedef struct packed {
    logic [2:0] tc_shift;   // [12:10] Low-pass shift, larger is slower.
    logic [2:0] pair;       // [9:7]   Phase pair, 1 is the first pair.
    logic       fall_zero;  // [6]     Differential falling level 0 V instead of 1.0 V.
    logic       rise_fixed; // [5]     Differential rising level fixed instead of adaptive.
    term_e      term;       // [4:2]
    mode_e      mode;       // [1:0]
  } cfg_s;

  localparam cfg_s CFG_RST = '{tc_shift: 3'h3, pair: 3'h1, fall_zero: 1'b0, rise_fixed: 1'b0,
                                term: TERM_OPEN, mode: MODE_DIGITAL};
  localparam logic [7:0]             DEBOUNCE_RST = 8'h32;
  localparam logic signed [VOLT_W-1:0] DIN_RISE_RST = 18'sh009C4;
  localparam logic signed [VOLT_W-1:0] DIN_FALL_RST = 18'sh003E8;
  localparam logic signed [VOLT_W-1:0] OV_RST       = 18'sh084D0;
  localparam logic signed [VOLT_W-1:0] UV_RST       = -18'sh01388;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic                               valid;
    logic [NUM_CH-1:0][VOLT_W-1:0]      mv;
  } volt_s;

  typedef struct packed {
    logic        adaptive;
    logic [15:0] rise_mv;
    logic [15:0] fall_mv;
  } thr_s;

endpackage : freq_input_pkg

// ### tb/freq_input_sva.sv
// Checker of port-level timing of the frequency input block.
`timescale 1ns/1ps
module freq_input_sva
  import freq_input_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYC,
  parameter int WINDOW_CYCLES = WINDOW_CYC,
  parameter int FREQ_CHANNELS = NUM_CH
)(
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               ce,
  input wire logic [ADDR_W-1:0]  addr,
  input wire logic [31:0]        wdata,
  input wire logic               wr,
  input wire logic               rd,
  input wire logic [31:0]        rdata,
  input wire volt_s              volt,
  input wire term_e [NUM_CH-1:0] term,
  input wire thr_s [NUM_CH-1:0]  freq_thr,
  input wire logic [NUM_CH-1:0]  digital_value,
  input wire logic [NUM_CH-1:0]  ov_fault,
  input wire logic [NUM_CH-1:0]  uv_fault,
  input wire logic               total_freq_fault
);
  logic       cfg_wr;
  logic [2:0] cfg_ch;
  term_e      cfg_term;

  // Captures the last configuration write so the termination output can be tied to it.
  always_ff @(posedge clk)
  begin
    cfg_wr   <= ce && wr && addr[3:0] == REG_CFG;
    cfg_ch   <= addr[6:4];
    cfg_term <= term_e'(wdata[4:2]);
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_rdata_idle: assert property (ce && !rd |=> rdata == 32'h0)
    else $error("Read data not zero outside a read answer.");
  a_ov_on_sample: assert property ($changed(ov_fault) |-> $past(volt.valid))
    else $error("Over-voltage flag moved without a voltage sample.");
  a_uv_on_sample: assert property ($changed(uv_fault) |-> $past(volt.valid))
    else $error("Under-voltage flag moved without a voltage sample.");
  // Threshold outputs are only judged from the third edge after reset release.
  for (genvar k = DIFF_CH; k < NUM_CH; k++)
  begin : g_se
    a_se_levels: assert property (rst_n && $past(rst_n) && $past(rst_n, 2) |->
      freq_thr[k] == thr_s'{1'b0, SE_RISE_MV, SE_FALL_MV})
      else $error("Single-ended comparator levels wrong.");
  end
  for (genvar k = 0; k < DIFF_CH; k++)
  begin : g_diff
    a_diff_levels: assert property (rst_n && $past(rst_n) && $past(rst_n, 2) |->
      freq_thr[k].rise_mv == FIX_RISE_DIFF_MV &&
      (freq_thr[k].fall_mv == FALL_HI_DIFF_MV || freq_thr[k].fall_mv == FALL_LO_DIFF_MV))
      else $error("Differential comparator levels wrong.");
  end
  a_term_follow: assert property (cfg_wr |-> term[cfg_ch] == cfg_term)
    else $error("Termination output does not follow the configuration.");
  a_dig_tick_hold: assert property ($changed(digital_value) |=> $stable(digital_value)[*8])
    else $error("Digital value moved between sample ticks.");
  a_tf_window_hold: assert property ($changed(total_freq_fault) |=> $stable(total_freq_fault)[*8])
    else $error("Total frequency flag moved inside a window.");

  c_ov: cover property ($rose(|ov_fault));
  c_uv: cover property ($rose(|uv_fault));
  c_dig: cover property ($rose(|digital_value));
endmodule : freq_input_sva

bind freq_input_measure freq_input_sva #(
  .SAMPLE_CYCLES(SAMPLE_CYCLES), .WINDOW_CYCLES(WINDOW_CYCLES), .FREQ_CHANNELS(FREQ_CHANNELS)
) i_sva (
  .clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .volt(volt), .term(term), .freq_thr(freq_thr), .digital_value(digital_value),
  .ov_fault(ov_fault), .uv_fault(uv_fault), .total_freq_fault(total_freq_fault)
);

// ### tb/sensor_model.sv
// Model of the sensors and switches that feed the input channels.
`timescale 1ns/1ps
module sensor_model
  import freq_input_pkg::*;
(
  input wire logic                          clk,
  input wire logic [NUM_CH-1:0][VOLT_W-1:0] mv_set,
  input wire logic [NUM_CH-1:0][15:0]       half,
  output volt_s                             volt,
  output logic [NUM_CH-1:0]                 cmp_in
);
  logic [1:0]               div;
  logic [NUM_CH-1:0][15:0]  cnt;

  initial
  begin
    volt = '0;
    cmp_in = '0;
    div = 2'h0;
    cnt = '0;
  end

  // Sample strobe every fourth cycle; comparator levels toggle each half period, still when zero.
  always @(posedge clk)
  begin
    div <= div + 2'h1;
    volt.valid <= div == 2'h0;
    volt.mv <= mv_set;
    for (int k = 0; k < NUM_CH; k++)
      if (half[k] == 16'h0)
        cnt[k] <= 16'h0;
      else if (cnt[k] >= half[k] - 16'h1)
      begin
        cnt[k] <= 16'h0;
        cmp_in[k] <= ~cmp_in[k];
      end
      else
        cnt[k] <= cnt[k] + 16'h1;
  end
endmodule : sensor_model

// ### tb/tb.sv
// Self-checking testbench of the frequency input block.
`timescale 1ns/1ps
module tb;
  import freq_input_pkg::*;
  logic                          clk, rst_n, ce, wr, rd;
  logic [ADDR_W-1:0]             addr;
  logic [31:0]                   wdata, rdata, seed, d, c1;
  logic [NUM_CH-1:0][VOLT_W-1:0] mv_set;
  logic [NUM_CH-1:0][15:0]       half;
  volt_s                         volt;
  logic [NUM_CH-1:0]             cmp_in, digital_value, ov_fault, uv_fault;
  term_e [NUM_CH-1:0]            term;
  thr_s [NUM_CH-1:0]             freq_thr;
  logic                          total_freq_fault;
  int                            miscompares, n_checks, v, ch;
  int                            corner [4] = '{34000, 34001, -5000, -5001};

  sensor_model i_sensor (.clk(clk), .mv_set(mv_set), .half(half), .volt(volt), .cmp_in(cmp_in));
  freq_input_measure #(.SAMPLE_CYCLES(50), .WINDOW_CYCLES(200), .FREQ_CHANNELS(8)) i_dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .volt(volt), .cmp_in(cmp_in), .term(term), .freq_thr(freq_thr), .digital_value(digital_value),
    .ov_fault(ov_fault), .uv_fault(uv_fault), .total_freq_fault(total_freq_fault));

  // Free-running 100 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [31:0] exp_fall(input int c, input logic fz);
    return (c < DIFF_CH) ? (fz ? 32'(FALL_LO_DIFF_MV) : 32'(FALL_HI_DIFF_MV)) : 32'(SE_FALL_MV);
  endfunction : exp_fall

  task automatic final_report(input int extra);
    miscompares += extra;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic wr_reg(input int c, input logic [3:0] r, input logic [31:0] wd);
    @(posedge clk);
    addr <= {3'(c), r};
    wdata <= wd;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input int c, input logic [3:0] r, output logic [31:0] rv);
    @(posedge clk);
    addr <= {3'(c), r};
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rv = rdata;
  endtask : rd_reg

  task automatic rchk(input int c, input logic [3:0] r, input logic [31:0] exp, input string msg);
    logic [31:0] rv;
    rd_reg(c, r, rv);
    chk(rv, exp, msg);
  endtask : rchk

  task automatic wait_dig(input int c, input logic lv, input int lim);
    int n;
    for (n = 0; n < lim && digital_value[c] !== lv; n++) step(1);
    if (n >= lim) final_report(1);
  endtask : wait_dig

  // Main sequence: reset, registers, voltage faults, digital path, frequency path.
  initial
  begin
    {rst_n, wr, rd, addr, wdata, mv_set, half} = '0;
    {ce, seed, miscompares, n_checks} = {1'b1, 32'd66939, 64'd0};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rchk(5, REG_CFG, 32'(CFG_RST), "cfg reset");
    rchk(5, REG_DEBOUNCE, 32'(DEBOUNCE_RST), "debounce reset");
    rchk(5, REG_DIN_RISE, 32'(DIN_RISE_RST), "rise reset");
    rchk(5, REG_DIN_FALL, 32'(DIN_FALL_RST), "fall reset");
    rchk(5, REG_OV_LIMIT, 32'(OV_RST), "ov reset");
    rchk(5, REG_UV_LIMIT, 32'(UV_RST), "uv reset");
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(5, REG_DEBOUNCE, 32'h7);
    ce <= 1'b1;
    wr_reg(5, 4'h7, 32'hFFFF);
    rchk(5, REG_DEBOUNCE, 32'(DEBOUNCE_RST), "write while frozen");
    rchk(5, 4'h7, 32'h0, "unmapped");
    $display("test registers done");
    for (int t = 0; t < 5; t++)
    begin
      seed = xs(seed);
      wr_reg(3'(t), REG_CFG, {19'h0, 3'h0, 3'h1, seed[1:0], 3'(t), 2'h0});
      step(2);
      chk(32'(term[t]), 32'(t), "termination");
      chk(32'(freq_thr[t].adaptive), 32'(t < DIFF_CH && !seed[0]), "adaptive");
      chk(32'(freq_thr[t].fall_mv), exp_fall(t, seed[1]), "falling level");
    end
    $display("test configuration done");
    for (int i = 0; i < 12; i++)
    begin
      seed = xs(seed);
      ch = int'(seed[2:0]) % 5;
      v = (i < 4) ? corner[i] : int'(seed[31:16] % 41000) - 6000;
      mv_set[ch] <= 18'(v);
      step(12);
      chk(32'(ov_fault[ch]), 32'(v > 34000), "ov flag");
      chk(32'(uv_fault[ch]), 32'(v < -5000), "uv flag");
      rchk(3'(ch), REG_VOLTAGE, 32'(v), "voltage");
      rd_reg(3'(ch), REG_STATUS, d);
      chk(32'(d[2:1]), {30'h0, v < -5000, v > 34000}, "status faults");
    end
    $display("test voltage done");
    wr_reg(3, REG_DEBOUNCE, 32'h2);
    mv_set <= '0;
    wait_dig(3, 1'b0, 300);
    repeat (3)
    begin
      mv_set[3] <= 18'd3000;
      step(60);
      mv_set[3] <= 18'd0;
      step(150);
    end
    chk(32'(digital_value[3]), 32'h0, "bounce");
    mv_set[3] <= 18'd3000;
    step(90);
    chk(32'(digital_value[3]), 32'h0, "debounce early");
    wait_dig(3, 1'b1, 300);
    mv_set[3] <= 18'd1500;
    step(300);
    chk(32'(digital_value[3]), 32'h1, "hysteresis hold");
    mv_set[3] <= 18'd1000;
    wait_dig(3, 1'b0, 300);
    mv_set[3] <= 18'd2500;
    wait_dig(3, 1'b1, 300);
    $display("test digital done");
    wr_reg(2, REG_CFG, 32'h1);
    wr_reg(0, REG_CFG, 32'h1);
    wr_reg(1, REG_CFG, 32'h83);
    half[2] <= 16'd1500;
    half[0] <= 16'd1500;
    step(7);
    half[1] <= 16'h05DC;
    step(8993);
    rd_reg(2, REG_COUNT, c1);
    step(8998);
    rd_reg(2, REG_COUNT, d);
    chk(d - c1, 32'd3, "pulse count");
    rchk(2, REG_PERIOD, 32'd3000, "period");
    rchk(0, REG_PERIOD, 32'd3000, "diff period");
    rchk(2, REG_HIGH, 32'd1500, "high time");
    rchk(0, REG_HIGH, 32'h0, "diff high time");
    rchk(2, REG_VOLTAGE, 32'h0, "no voltage");
    wr_reg(2, REG_COUNT, 32'hFFFF);
    step(2997);
    rchk(2, REG_COUNT, 32'h0, "count wrap");
    rchk(1, REG_PHASE, 32'h7, "phase");
    chk(32'(total_freq_fault), 32'h0, "total frequency");
    $display("test frequency done");
    final_report(0);
  end
endmodule : tb
